// File: src/dsr_pkg.sv
package dsr_pkg;
    // geometry
    localparam int NCH = 6;
    localparam int CH_W = 3;
    localparam int CNT_W = 24;
    localparam int MODE_W = 3;
    localparam int ADDR_W = 8;
    localparam int RAM_AW = 16;
    // 256-word ram banks: bank number starts at this address bit
    localparam int BANK_LSB = 8;

    // apb register byte addresses
    localparam logic [ADDR_W-1:0] A_STAT = 8'h00;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] A_CTRL_END = 8'h1C;
    localparam logic [ADDR_W-1:0] A_CNT = 8'h1C;
    localparam logic [ADDR_W-1:0] A_CNT_END = 8'h34;
    localparam logic [ADDR_W-1:0] A_ERR = 8'h34;

    // status word layout
    localparam int STAT_W = 24;
    localparam int ST_DONE_LSB = 0;
    localparam int ST_ACT_BIT = 8;
    localparam int ST_CH_LSB = 9;
    localparam logic [NCH-1:0] DONE_RST = 6'h3F;

    // channel control word layout
    localparam int CT_EN_BIT = 0;
    localparam int CT_IE_BIT = 1;
    localparam int CT_MODE_LSB = 2;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
    // transfer mode field: bit 0 word mode, bit 1 keep enable at done
    localparam int MODE_WORD_BIT = 0;
    localparam int MODE_KEEP_BIT = 1;

    // cycles from enable set until the done flag responds
    localparam logic [1:0] EN_DLY = 2'h2;

    typedef enum logic {
        ENG_IDLE,
        ENG_MOVE
    } dsr_eng_e;
endpackage

// File: src/dsr_chan.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_chan
    import dsr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control from register file
    input wire logic en,
    input wire logic en_set,
    input wire logic word_mode,
    input wire logic keep_en,
    input wire logic [CNT_W-1:0] cnt_init,
    // events
    input wire logic trig,
    input wire logic stop,
    input wire logic served,
    // state out
    output logic req,
    output logic done,
    output logic clr_en,
    output logic accept
);
    typedef struct packed {
        logic [1:0] dly;
        logic done;
        logic pend;
        logic [CNT_W-1:0] cnt;
    } dsr_chan_s;

    dsr_chan_s s;
    dsr_chan_s n;
    logic running;

    assign running = en & ~s.done;

    always_comb begin
        n = s;
        clr_en = 1'b0;
        accept = 1'b0;
        if (s.dly != 2'h0) begin
            n.dly = s.dly - 2'h1;
            if (s.dly == 2'h1 && en) begin
                n.done = 1'b0;
                n.cnt = cnt_init;
            end
        end
        // done cleared only by enable set
        if (en_set) begin
            n.dly = EN_DLY;
        end
        if (stop) begin
            n.pend = 1'b0;
        end else if (trig && running && !s.pend) begin
            n.pend = 1'b1;
            accept = 1'b1;
        end
        if (served) begin
            // last when counter reloads or enable cleared
            if (s.cnt == '0 || !en) begin
                n.done = 1'b1;
                n.pend = 1'b0;
                n.cnt = cnt_init;
                clr_en = (s.cnt == '0) & ~keep_en;
            end else begin
                n.cnt = s.cnt - 1'b1;
                if (word_mode) begin
                    n.pend = 1'b0;
                end
            end
        end else if (!en && !s.done && !(word_mode && s.pend)) begin
            n.done = 1'b1;
            n.pend = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.dly <= 2'h0;
            s.done <= 1'b1;
            s.pend <= 1'b0;
            s.cnt <= '0;
        end else begin
            s <= n;
        end
    end

    assign req = s.pend & ~s.done;
    assign done = s.done;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enable;
        en_set && s.done ##1 en [*2];
    endsequence

    property p_done_hold;
        en_set && s.done |=> s.done [*2];
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done cleared too early");

    property p_done_clr;
        s_enable |=> !s.done;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");

    property p_stop;
        stop |=> !s.pend;
    endproperty
    a_stop: assert property (p_stop) else $error("trigger kept over stop");

    property p_last;
        served && s.cnt == '0 |=> s.done && s.cnt == $past(cnt_init);
    endproperty
    a_last: assert property (p_last) else $error("last word did not set done");
endmodule
`default_nettype wire

// File: src/dsr_top.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 24-bit status register is read-only; writes leave it unchanged.
// - channel done flag, bits 5..0, set when last word stored; channel stops.
// - at done, enable is cleared or kept as the transfer mode says.
// - last transfer is counter reload or software clearing enable.
// - done with irq enable set raises a dma interrupt request.
// - done flags set by reset, cleared only by setting enable.
// - done flag responds two cycles after enable is set.
// - word mode disable sets done after a captured trigger is served.
// - status bits 23..12 and 7..6 read zero.
// - active bit 8 high during transfer; low when idle and at reset.
// - bits 11..9 give active channel 0..5, reset to zero.
// - entering stop discards all latched triggers.
// - accepted trigger wakes core; active dma blocks wait entry.
// - io space accesses only to peripheral data registers.
// - external access stall halts every channel.
// - same ram bank: core wins, dma waits; different banks run freely.
module dsr_top
    import dsr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // triggers and processing state
    input wire logic [NCH-1:0] dma_trig,
    input wire logic stop_state,
    // transfer path
    input wire logic xfer_ext,
    input wire logic ext_wait_pin,
    input wire logic xfer_io,
    input wire logic periph_data_hit,
    input wire logic xfer_ram,
    input wire logic [RAM_AW-1:0] xfer_ram_addr,
    input wire logic core_ram_req,
    input wire logic [RAM_AW-1:0] core_ram_addr,
    output logic xfer_valid,
    output logic [CH_W-1:0] xfer_chan,
    output logic xfer_strobe,
    // core interaction
    output logic [NCH-1:0] dma_irq_req,
    output logic core_wake,
    output logic core_wait_block
);
    typedef struct packed {
        logic [NCH-1:0] en;
        logic [NCH-1:0] ie;
        logic [NCH-1:0][MODE_W-1:0] mode;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic io_err;
        dsr_eng_e st;
        logic [CH_W-1:0] ch;
        logic ew1;
        logic ew2;
        logic [31:0] rdata;
        logic slverr;
    } dsr_top_s;

    dsr_top_s s;
    dsr_top_s n;

    logic [NCH-1:0] req;
    logic [NCH-1:0] done;
    logic [NCH-1:0] clr_en;
    logic [NCH-1:0] accept;
    logic [NCH-1:0] en_set;
    logic [NCH-1:0] served;
    logic act;
    logic stall;
    logic bank_hit;
    logic io_ok;
    logic [STAT_W-1:0] status;
    logic [ADDR_W-1:0] off_ctrl;
    logic [ADDR_W-1:0] off_cnt;
    logic [CH_W-1:0] ictrl;
    logic [CH_W-1:0] icnt;
    logic is_stat;
    logic is_ctrl;
    logic is_cnt;
    logic is_err;
    logic acc_wr;
    logic [NCH-1:0] wr_ctrl;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            dsr_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .en(s.en[g]),
                .en_set(en_set[g]),
                .word_mode(s.mode[g][MODE_WORD_BIT]),
                .keep_en(s.mode[g][MODE_KEEP_BIT]),
                .cnt_init(s.cnt[g]),
                .trig(dma_trig[g]),
                .stop(stop_state),
                .served(served[g]),
                .req(req[g]),
                .done(done[g]),
                .clr_en(clr_en[g]),
                .accept(accept[g])
            );
        end
    endgenerate

    // active while moving or work pending
    assign act = (s.st == ENG_MOVE) | (|req);

    assign status = {12'h000, s.ch, act, 2'b00, done};

    assign bank_hit = xfer_ram & core_ram_req &
        (xfer_ram_addr[RAM_AW-1:BANK_LSB] == core_ram_addr[RAM_AW-1:BANK_LSB]);
    // one engine, so any stall halts all
    assign stall = (xfer_ext & s.ew2) | bank_hit;
    // io accesses limited to data registers
    assign io_ok = ~xfer_io | periph_data_hit;

    // address decode, word aligned only
    assign off_ctrl = paddr - A_CTRL;
    assign off_cnt = paddr - A_CNT;
    assign ictrl = off_ctrl[4:2];
    assign icnt = off_cnt[4:2];
    assign is_stat = (paddr == A_STAT);
    assign is_ctrl = (paddr >= A_CTRL) && (paddr < A_CTRL_END) && (paddr[1:0] == 2'b00);
    assign is_cnt = (paddr >= A_CNT) && (paddr < A_CNT_END) && (paddr[1:0] == 2'b00);
    assign is_err = (paddr == A_ERR);
    assign acc_wr = psel & penable & pwrite;

    always_comb begin
        n = s;
        en_set = '0;
        served = '0;
        wr_ctrl = '0;
        // pin passes two flops before use
        n.ew1 = ext_wait_pin;
        n.ew2 = s.ew1;
        for (int i = 0; i < NCH; i++) begin
            if (clr_en[i]) begin
                n.en[i] = 1'b0;
            end
        end
        // read data captured in setup; status read is side-effect free
        if (psel && !penable) begin
            n.slverr = !(is_stat || is_ctrl || is_cnt || is_err);
            n.rdata = 32'h0000_0000;
            if (is_stat) begin
                n.rdata = {8'h00, status};
            end else if (is_ctrl) begin
                n.rdata[CT_EN_BIT] = s.en[ictrl];
                n.rdata[CT_IE_BIT] = s.ie[ictrl];
                n.rdata[CT_MODE_LSB +: MODE_W] = s.mode[ictrl];
            end else if (is_cnt) begin
                n.rdata[CNT_W-1:0] = s.cnt[icnt];
            end else if (is_err) begin
                n.rdata[0] = s.io_err;
            end
        end
        if (acc_wr) begin
            if (is_ctrl) begin
                wr_ctrl[ictrl] = 1'b1;
                n.en[ictrl] = pwdata[CT_EN_BIT];
                en_set[ictrl] = pwdata[CT_EN_BIT] & ~s.en[ictrl];
                n.ie[ictrl] = pwdata[CT_IE_BIT];
                n.mode[ictrl] = pwdata[CT_MODE_LSB +: MODE_W];
            end else if (is_cnt) begin
                n.cnt[icnt] = pwdata[CNT_W-1:0];
            end else if (is_err && pwdata[0]) begin
                n.io_err = 1'b0;
            end
        end
        // transfer engine, lowest channel number first
        case (s.st)
            ENG_IDLE: begin
                for (int i = NCH - 1; i >= 0; i--) begin
                    if (req[i]) begin
                        n.ch = CH_W'(i);
                        n.st = ENG_MOVE;
                    end
                end
            end
            ENG_MOVE: begin
                if (!req[s.ch]) begin
                    n.st = ENG_IDLE;
                // core wins the bank; dma waits
                end else if (!stall) begin
                    served[s.ch] = 1'b1;
                    n.st = ENG_IDLE;
                    // set wins over software clear
                    if (!io_ok) begin
                        n.io_err = 1'b1;
                    end
                end
            end
            default: begin
                n.st = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.en <= '0;
            s.ie <= '0;
            s.mode <= {NCH{MODE_RST}};
            s.cnt <= '0;
            s.io_err <= 1'b0;
            s.st <= ENG_IDLE;
            s.ch <= '0;
            s.ew1 <= 1'b0;
            s.ew2 <= 1'b0;
            s.rdata <= 32'h0000_0000;
            s.slverr <= 1'b0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = s.slverr;

    assign xfer_valid = (s.st == ENG_MOVE);
    assign xfer_chan = s.ch;
    // io access to a non data register is suppressed
    assign xfer_strobe = (|served) & io_ok;

    assign dma_irq_req = done & s.ie;
    // wake on accepted trigger, block wait while active
    assign core_wake = |accept;
    assign core_wait_block = act;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stat_read;
        psel && !penable && !pwrite && is_stat ##1 psel && penable;
    endsequence

    property p_rsvd;
        s_stat_read |-> prdata[31:12] == 20'h0_0000 && prdata[7:6] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits nonzero");

    property p_stat_done;
        s_stat_read |-> prdata[5:0] == $past(done);
    endproperty
    a_stat_done: assert property (p_stat_done) else $error("status done mismatch");

    property p_bank;
        s.st == ENG_MOVE && bank_hit |-> served == '0 ##1 s.st == ENG_MOVE;
    endproperty
    a_bank: assert property (p_bank) else $error("dma took a busy bank");

    property p_ext;
        s.st == ENG_MOVE && xfer_ext && s.ew2 |-> served == '0;
    endproperty
    a_ext: assert property (p_ext) else $error("transfer past external stall");

    property p_io;
        xfer_strobe |-> !xfer_io || periph_data_hit;
    endproperty
    a_io: assert property (p_io) else $error("io access to non data register");

    property p_act;
        s.st == ENG_MOVE |-> status[ST_ACT_BIT] && status[ST_CH_LSB +: CH_W] < 3'h6;
    endproperty
    a_act: assert property (p_act) else $error("active flag or code wrong");

    property p_clr_en;
        clr_en[0] && !wr_ctrl[0] |=> !s.en[0];
    endproperty
    a_clr_en: assert property (p_clr_en) else $error("enable not cleared at done");

    property p_wait;
        |req |-> core_wait_block;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not blocked while active");
endmodule
`default_nettype wire

// File: test/dsr_far.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_far
    import dsr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // engine side
    input wire logic xfer_valid,
    input wire logic [CH_W-1:0] xfer_chan,
    input wire logic xfer_strobe,
    // scenario control
    input wire logic [1:0] target,
    input wire logic hold,
    input wire logic bad_io,
    input wire logic core_on,
    input wire logic core_same,
    // transfer path
    output logic xfer_ext,
    output logic ext_wait_pin,
    output logic xfer_io,
    output logic periph_data_hit,
    output logic xfer_ram,
    output logic [RAM_AW-1:0] xfer_ram_addr,
    output logic core_ram_req,
    output logic [RAM_AW-1:0] core_ram_addr,
    output logic [15:0] words
);
    logic [RAM_AW-1:0] addr;
    assign addr = {8'h01, 5'h00, xfer_chan};
    assign xfer_ext = xfer_valid && target == 2'h0;
    assign ext_wait_pin = hold;
    assign xfer_io = xfer_valid && target == 2'h2;
    assign periph_data_hit = !bad_io;
    // bank one, core bank one or three
    assign xfer_ram = xfer_valid && target == 2'h1;
    // released address lines flip, so no stale value passes
    assign xfer_ram_addr = xfer_ram ? addr : ~addr;
    assign core_ram_req = core_on;
    assign core_ram_addr = core_same ? 16'h0180 : 16'h0300;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            words <= 16'h0000;
        end else if (xfer_strobe) begin
            words <= words + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: test/test_dma_status_and_channel_rules.sv
`timescale 1ns/1ps
`default_nettype none
module test_dma_status_and_channel_rules
    import dsr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_state;
    logic xfer_ext, ext_wait_pin, xfer_io, periph_data_hit, xfer_ram, core_ram_req;
    logic xfer_valid, xfer_strobe, core_wake, core_wait_block;
    logic hold, bad_io, core_on, core_same, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0] dma_trig, dma_irq_req;
    logic [RAM_AW-1:0] xfer_ram_addr, core_ram_addr;
    logic [CH_W-1:0] xfer_chan;
    logic [1:0] target;
    logic [15:0] words, w0;
    int err_total, tests_run, cyc;

    dsr_top dsr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_trig(dma_trig), .stop_state(stop_state), .xfer_ext(xfer_ext),
        .ext_wait_pin(ext_wait_pin), .xfer_io(xfer_io), .periph_data_hit(periph_data_hit),
        .xfer_ram(xfer_ram), .xfer_ram_addr(xfer_ram_addr), .core_ram_req(core_ram_req),
        .core_ram_addr(core_ram_addr), .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
        .xfer_strobe(xfer_strobe), .dma_irq_req(dma_irq_req), .core_wake(core_wake),
        .core_wait_block(core_wait_block));
    dsr_far dsr_far_inst (.pclk(pclk), .presetn(presetn), .xfer_valid(xfer_valid),
        .xfer_chan(xfer_chan), .xfer_strobe(xfer_strobe), .target(target), .hold(hold),
        .bad_io(bad_io), .core_on(core_on), .core_same(core_same), .xfer_ext(xfer_ext),
        .ext_wait_pin(ext_wait_pin), .xfer_io(xfer_io), .periph_data_hit(periph_data_hit),
        .xfer_ram(xfer_ram), .xfer_ram_addr(xfer_ram_addr), .core_ram_req(core_ram_req),
        .core_ram_addr(core_ram_addr), .words(words));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task close_out;
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // enable settles first, then a one-cycle trigger
    task pulse(input int ch);
        repeat (4) @(posedge pclk);
        w0 = words;
        dma_trig <= NCH'(1 << ch);
        @(posedge pclk);
        chk(32'(core_wake), 32'h1);
        dma_trig <= '0;
    endtask

    task poll(input int b);
        int i;
        rd = '0;
        for (i = 0; i < 100 && rd[b] !== 1'b1; i++) begin
            apb(1'b0, A_STAT, 32'h0);
        end
        chk(32'(rd[b]), 32'h1);
    endtask

    task setup(input int ch, input logic [31:0] cnt, input logic [31:0] ctrl);
        apb(1'b1, A_CNT + ADDR_W'(4 * ch), cnt);
        apb(1'b1, A_CTRL + ADDR_W'(4 * ch), ctrl);
    endtask

    task t_reset;
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h0000003F);
        apb(1'b1, A_STAT, 32'hFFFFFFFF);
        apb(1'b0, A_STAT, 32'h0);
        chk({31'h0, er}, 32'h0);
        chk(rd, 32'h0000003F);
        chk(32'(dma_irq_req), 32'h0);
        apb(1'b0, 8'h38, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b0, 8'h05, 32'h0);
        chk(32'(er), 32'h1);
    endtask

    task t_block;
        setup(0, 32'h2, 32'h3);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[0]), 32'h1);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[0]), 32'h0);
        pulse(0);
        poll(0);
        chk(32'(words - w0), 32'h3);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h2);
        chk(32'(dma_irq_req), 32'h1);
    endtask

    task t_keep;
        setup(1, 32'h0, 32'h9);
        pulse(1);
        poll(1);
        chk(32'(words - w0), 32'h1);
        apb(1'b0, A_CTRL + 8'h04, 32'h0);
        chk(rd, 32'h9);
        chk(32'(dma_irq_req), 32'h1);
    endtask

    task t_stall;
        target <= 2'h0;
        hold <= 1'b1;
        setup(2, 32'h1, 32'h1);
        pulse(2);
        repeat (10) @(posedge pclk);
        chk(32'(words - w0), 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h0000053B);
        chk(32'(core_wait_block), 32'h1);
        hold <= 1'b0;
        poll(2);
        chk(32'(words - w0), 32'h2);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[8:0]), 32'h3F);
        chk(32'(core_wait_block), 32'h0);
    endtask

    task t_bank;
        target <= 2'h1;
        core_on <= 1'b1;
        core_same <= 1'b1;
        setup(3, 32'h0, 32'h1);
        pulse(3);
        repeat (10) @(posedge pclk);
        chk(32'(words - w0), 32'h0);
        core_same <= 1'b0;
        poll(3);
        chk(32'(words - w0), 32'h1);
        core_on <= 1'b0;
    endtask

    task t_word;
        target <= 2'h0;
        hold <= 1'b1;
        setup(4, 32'h5, 32'h5);
        pulse(4);
        apb(1'b1, A_CTRL + 8'h10, 32'h4);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[4]), 32'h0);
        // done waits for the channel's own turn
        hold <= 1'b0;
        poll(4);
        chk(32'(words - w0), 32'h1);
    endtask

    task t_io;
        target <= 2'h2;
        bad_io <= 1'b1;
        setup(5, 32'h0, 32'h1);
        pulse(5);
        repeat (10) @(posedge pclk);
        chk(32'(words - w0), 32'h0);
        apb(1'b0, A_ERR, 32'h0);
        chk(rd, 32'h1);
        bad_io <= 1'b0;
        apb(1'b1, A_ERR, 32'h1);
        apb(1'b0, A_ERR, 32'h0);
        chk(rd, 32'h0);
    endtask

    // a latched trigger must not survive a stop
    task t_stop;
        target <= 2'h0;
        hold <= 1'b1;
        setup(0, 32'h0, 32'h1);
        pulse(0);
        stop_state <= 1'b1;
        @(posedge pclk);
        stop_state <= 1'b0;
        hold <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(32'(words - w0), 32'h0);
        // active flag reads low after stop
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[8]), 32'h0);
        apb(1'b1, A_CTRL, 32'h0);
        poll(0);
    endtask

    // bound far above the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, stop_state, hold, bad_io, core_on, core_same} = '0;
        paddr = '0;
        pwdata = '0;
        dma_trig = '0;
        target = 2'h1;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_block();
        t_keep();
        t_stall();
        t_bank();
        t_word();
        t_io();
        t_stop();
        close_out();
    end
endmodule
`default_nettype wire
